/* src/fsp_ctrl.sv */
// Flash self-programming controller: control register, timed windows,
// configuration readback, programming timer and boot size decode.
// Assumes the core end drives the interface; flash array is outside.
//
// Operation
// - Lock byte read at index 0x0001
// - Auto-clear select bits on done/timeout
// - Loads read flash once bits clear
// - Lock byte layout bits 5..0
// - Fuse low byte read at 0x0000
// - Fuse high byte read at 0x0003
// - Extended fuse read at 0x0002, bits 2..0
// - Programmed reads zero, unprogrammed one
// - Signature byte read via signature select
// - Signature select auto-clears, three cycles
// - Identity bytes at 0x0000, 0x0002, 0x0004
// - Calibration byte at 0x0001, others reserved
// - Write in progress survives reset
// - Programming lasts 3.7 to 4.5 ms
// - Software polls enable clear first
// - Software waits EEPROM idle, no interrupts
// - Software re-enables busy section
// - Boot size fuses select boot start
// - Page erase pattern, store within four
// - Page write pattern, word bits zero
// - Section busy until re-enable written
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module fsp_ctrl #(
   parameter int PROG_CYC = fsp_pkg::PROG_CYCLES, // Programming duration
   parameter logic [7:0] SIG_BYTE1 = 8'h5a,       // Arbitrary identity value
   parameter logic [7:0] SIG_BYTE2 = 8'h3c,       // Arbitrary identity value
   parameter logic [7:0] SIG_BYTE3 = 8'h11        // Arbitrary identity value
) (
   input wire logic clk_i,               // CPU clock
   input wire logic rst_n_i,             // Sync reset, active low
   fsp_if.ctrl bus,                      // Core side
   input wire logic [5:0] lock_bits_i,   // Stored lock bits, 0 = programmed
   input wire logic [7:0] fuse_low_byte_i,  // Stored fuse low byte
   input wire logic [7:0] fuse_high_byte_i, // Stored fuse high byte
   input wire logic [2:0] extended_fuse_byte_i, // Stored extended fuse
   input wire logic [7:0] osc_cal_i,     // Oscillator calibration byte
   input wire logic [7:0] flash_rdata_i, // Flash array byte at zptr
   output logic flash_erase_o,           // Page erase in progress
   output logic flash_write_o,           // Page write in progress
   output logic lock_write_o,            // Lock write in progress
   output logic [5:0] lock_wdata_o,      // Lock bits to program
   output logic [15:0] prog_page_o,      // Latched page address
   output logic [15:0] boot_start_o,     // Boot section start word
   output logic [12:0] boot_words_o      // Boot section size, words
);
   import fsp_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_WRITE, ST_LOCKW} fsp_op_e;

   logic [7:0] ctl_r, ctl_nxt;
   logic [2:0] win_r, win_nxt;
   logic [22:0] tmr_r, tmr_nxt;
   fsp_op_e op_r, op_nxt;
   logic [7:0] rb_r, rb_nxt;
   logic [15:0] page_r, page_nxt;
   logic [5:0] lockw_r, lockw_nxt;
   logic [6:0] cmd;
   logic sp_en;

   assign cmd = ctl_r[6:0] & ~7'h40;
   assign sp_en = ctl_r[CTL_ENABLE];

   // Next-state for control register, window and programming timer
   always_comb begin
      ctl_nxt = ctl_r;
      win_nxt = win_r;
      tmr_nxt = tmr_r;
      op_nxt = op_r;
      page_nxt = page_r;
      lockw_nxt = lockw_r;
      if (op_r != ST_IDLE) begin
         // Enable held for the whole operation; READ_WHILE_WRITE_SECTION busy stays set after it until re-enable
         if (tmr_r == 23'(PROG_CYC - 1)) begin
            op_nxt = ST_IDLE;
            ctl_nxt[CTL_ENABLE] = 1'b0;
            ctl_nxt[CTL_ERASE] = 1'b0;
            ctl_nxt[CTL_WRITE] = 1'b0;
            ctl_nxt[CTL_LOCK_SEL] = 1'b0;
         end else begin
            tmr_nxt = tmr_r + 23'd1;
         end
      end else if (sp_en) begin
         if (bus.spm && cmd == CMD_PAGE_ERASE) begin
            op_nxt = ST_ERASE;
            tmr_nxt = '0;
            page_nxt = bus.zptr;
            ctl_nxt[CTL_RWW_BUSY] = 1'b1;
         end else if (bus.spm && cmd == CMD_PAGE_WRITE &&
                      bus.zptr[7:1] == 7'h00) begin
            op_nxt = ST_WRITE;
            tmr_nxt = '0;
            page_nxt = bus.zptr;
            ctl_nxt[CTL_RWW_BUSY] = 1'b1;
         end else if (bus.spm && cmd == CMD_LOCK_WRITE) begin
            op_nxt = ST_LOCKW;
            tmr_nxt = '0;
            lockw_nxt = bus.r1r0[5:0];
         end else if (bus.spm && cmd != CMD_PAGE_WRITE) begin
            // Page load and re-enable complete at once; a bad page
            // write is not taken and is left to time out
            if (cmd == CMD_RWW_REEN) ctl_nxt[CTL_RWW_BUSY] = 1'b0;
            ctl_nxt = ctl_nxt & ~8'h3f;
         end else if (bus.pm_load && (ctl_r[CTL_LOCK_SEL] || ctl_r[CTL_SIG_SEL]) &&
                      win_r < 3'(LOAD_WINDOW)) begin
            ctl_nxt = ctl_nxt & ~8'h3f;
         end else if ((ctl_r[CTL_SIG_SEL] && win_r == 3'(LOAD_WINDOW - 1)) ||
                      win_r == 3'(STORE_WINDOW - 1)) begin
            ctl_nxt = ctl_nxt & ~8'h3f;
         end else begin
            win_nxt = win_r + 3'd1;
         end
      end
      // A new command is taken only when idle and EEPROM quiet
      if (bus.ctl_wr && op_r == ST_IDLE && !sp_en && !bus.eeprom_write_busy) begin
         // Bit 7 unused; the busy flag belongs to hardware
         ctl_nxt = {1'b0, ctl_r[CTL_RWW_BUSY], bus.ctl_wdata[5:0]};
         win_nxt = '0;
      end
   end

   // Load data: configuration byte while selected, else flash
   always_comb begin
      rb_nxt = rb_r;
      if (bus.pm_load) begin
         rb_nxt = flash_rdata_i;
         if (sp_en && op_r == ST_IDLE && win_r < 3'(LOAD_WINDOW) &&
             cmd == CMD_LOCK_READ) begin
            if (bus.zptr == ADR_LOCK)
               rb_nxt = {2'b11, lock_bits_i};
            else if (bus.zptr == ADR_FUSE_LOW)
               rb_nxt = fuse_low_byte_i;
            else if (bus.zptr == ADR_FUSE_HIGH)
               rb_nxt = fuse_high_byte_i;
            else if (bus.zptr == ADR_FUSE_EXT)
               rb_nxt = {5'h1f, extended_fuse_byte_i};
            else
               rb_nxt = RESERVED_BYTE;
         end else if (sp_en && op_r == ST_IDLE && win_r < 3'(LOAD_WINDOW) &&
                      cmd == CMD_SIG_READ) begin
            if (bus.zptr == ADR_SIG1)
               rb_nxt = SIG_BYTE1;
            else if (bus.zptr == ADR_SIG2)
               rb_nxt = SIG_BYTE2;
            else if (bus.zptr == ADR_SIG3)
               rb_nxt = SIG_BYTE3;
            else if (bus.zptr == ADR_CAL)
               rb_nxt = osc_cal_i;
            else
               rb_nxt = RESERVED_BYTE;
         end
      end
   end

   // Registers; a running operation ignores reset so the write ends
   always_ff @(posedge clk_i) begin
      if (!rst_n_i && op_nxt == ST_IDLE) begin
         // Known load result after reset, never unknown
         rb_r <= RESERVED_BYTE;
         ctl_r <= CTL_RESET;
         win_r <= '0;
         tmr_r <= '0;
         op_r <= ST_IDLE;
         page_r <= '0;
         lockw_r <= '1;
      end else if (!rst_n_i) begin
         // Keep the timer running; only the window restarts
         ctl_r <= ctl_nxt;
         win_r <= '0;
         tmr_r <= tmr_nxt;
         op_r <= op_nxt;
         rb_r <= rb_nxt;
         page_r <= page_r;
         lockw_r <= lockw_r;
      end else begin
         ctl_r <= ctl_nxt;
         rb_r <= rb_nxt;
         win_r <= win_nxt;
         tmr_r <= tmr_nxt;
         op_r <= op_nxt;
         page_r <= page_nxt;
         lockw_r <= lockw_nxt;
      end
   end

   // Boot section decode from the size fuses (fuse high bits 2:1)
   always_comb begin
      case (fuse_high_byte_i[2:1])
         2'b11: begin boot_start_o = BOOT_START_11; boot_words_o = BOOT_WORDS_11; end
         2'b10: begin boot_start_o = BOOT_START_10; boot_words_o = BOOT_WORDS_10; end
         2'b01: begin boot_start_o = BOOT_START_01; boot_words_o = BOOT_WORDS_01; end
         default: begin boot_start_o = BOOT_START_00; boot_words_o = BOOT_WORDS_00; end
      endcase
   end

   assign bus.ctl_rdata = ctl_r;
   assign bus.load_data = rb_r;
   assign flash_erase_o = (op_r == ST_ERASE);
   assign flash_write_o = (op_r == ST_WRITE);
   assign lock_write_o = (op_r == ST_LOCKW);
   assign lock_wdata_o = lockw_r;
   assign prog_page_o = page_r;
endmodule : fsp_ctrl
`default_nettype wire

/* common/fsp_pkg.sv */
// Package for the flash self-programming control path: control bit
// positions, readback addresses, boot size table and timing counts.
// Assumes a single 10 MHz CPU clock shared by both ends.
package fsp_pkg;
   // Control register bit positions
   localparam int CTL_ENABLE = 0;
   localparam int CTL_ERASE = 1;
   localparam int CTL_WRITE = 2;
   localparam int CTL_LOCK_SEL = 3;
   localparam int CTL_REENABLE = 4;
   localparam int CTL_SIG_SEL = 5;
   localparam int CTL_RWW_BUSY = 6;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // Command patterns, bit 7 ignored
   localparam logic [6:0] CMD_PAGE_LOAD = 7'h01;
   localparam logic [6:0] CMD_PAGE_ERASE = 7'h03;
   localparam logic [6:0] CMD_PAGE_WRITE = 7'h05;
   localparam logic [6:0] CMD_LOCK_WRITE = 7'h09;
   localparam logic [6:0] CMD_LOCK_READ = 7'h09;
   localparam logic [6:0] CMD_RWW_REEN = 7'h11;
   localparam logic [6:0] CMD_SIG_READ = 7'h21;
   // Index pointer addresses for configuration readback
   localparam logic [15:0] ADR_FUSE_LOW = 16'h0000;
   localparam logic [15:0] ADR_LOCK = 16'h0001;
   localparam logic [15:0] ADR_FUSE_EXT = 16'h0002;
   localparam logic [15:0] ADR_FUSE_HIGH = 16'h0003;
   localparam logic [15:0] ADR_SIG1 = 16'h0000;
   localparam logic [15:0] ADR_CAL = 16'h0001;
   localparam logic [15:0] ADR_SIG2 = 16'h0002;
   localparam logic [15:0] ADR_SIG3 = 16'h0004;
   localparam logic [7:0] RESERVED_BYTE = 8'hff;
   // Timed windows in CPU cycles
   localparam int LOAD_WINDOW = 3;
   localparam int STORE_WINDOW = 4;
   // Programming time
   localparam int CLK_HZ = 10_000_000;
   localparam int PROG_MIN_US = 3700;
   localparam int PROG_MAX_US = 4500;
   localparam int PROG_CYCLES = (PROG_MIN_US * (CLK_HZ / 1_000_000) + PROG_MAX_US
                                 * (CLK_HZ / 1_000_000)) / 2;
   // Boot section start per size code
   localparam logic [15:0] BOOT_START_11 = 16'h7e00;
   localparam logic [15:0] BOOT_START_10 = 16'h7c00;
   localparam logic [15:0] BOOT_START_01 = 16'h7800;
   localparam logic [15:0] BOOT_START_00 = 16'h7000;
   localparam logic [12:0] BOOT_WORDS_11 = 13'd512;
   localparam logic [12:0] BOOT_WORDS_10 = 13'd1024;
   localparam logic [12:0] BOOT_WORDS_01 = 13'd2048;
   localparam logic [12:0] BOOT_WORDS_00 = 13'd4096;
   localparam logic [6:0] WORD_SEL_MASK = 7'h7f;
endpackage : fsp_pkg

/* common/fsp_if.sv */
// Interface between the CPU side (core) and the flash controller side.
// Assumes both ends share clk; strobes are one cycle long.
`timescale 1ns/10ps
`default_nettype none
interface fsp_if (
   input wire logic clk
);
   logic ctl_wr;         // Control register write strobe
   logic [7:0] ctl_wdata; // Control register write data
   logic [7:0] ctl_rdata; // Control register read value
   logic [15:0] zptr;    // Index pointer
   logic [15:0] r1r0;    // Store data
   logic pm_load;        // Program memory load strobe
   logic spm;            // Program memory store strobe
   logic [7:0] load_data; // Load result, valid cycle after the load
   logic eeprom_write_busy; // EEPROM write in progress
   modport ctrl (input clk, ctl_wr, ctl_wdata, zptr, r1r0, pm_load, spm, eeprom_write_busy,
                 output ctl_rdata, load_data);
   modport core (input clk, ctl_rdata, load_data,
                 output ctl_wr, ctl_wdata, zptr, r1r0, pm_load, spm, eeprom_write_busy);
endinterface : fsp_if
`default_nettype wire

/* src/fsp_core.sv */
// Core end: turns user-side requests into control writes, loads and
// stores on the interface, polling the enable bit before each command.
// Assumes the controller end answers a load in the following cycle.
`timescale 1ns/10ps
`default_nettype none
module fsp_core (
   input wire logic clk_i,            // CPU clock
   input wire logic rst_n_i,          // Sync reset, active low
   fsp_if.core bus,                   // Controller side
   input wire logic req_i,            // Start one command
   input wire logic [7:0] cmd_i,      // Control pattern
   input wire logic is_load_i,        // Follow with load, else store
   input wire logic [15:0] zptr_i,    // Index pointer
   input wire logic [15:0] data_i,    // Store data
   input wire logic ee_busy_i,        // EEPROM write in progress
   output logic busy_o,               // Command in flight
   output logic done_o,               // One-cycle completion pulse
   output logic [7:0] rdata_o,        // Load result
   output logic [7:0] status_o        // Last control register value
);
   import fsp_pkg::*;

   typedef enum logic [2:0] {C_IDLE, C_POLL, C_WR, C_ACC, C_CAP} fsp_cst_e;

   fsp_cst_e st_r, st_nxt;
   logic [7:0] cmd_r, cmd_nxt, rd_r, rd_nxt;
   logic ld_r, ld_nxt;
   logic [15:0] z_r, z_nxt, d_r, d_nxt;

   // Sequencer: poll enable clear, wait EEPROM, write, then access
   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      ld_nxt = ld_r;
      z_nxt = z_r;
      d_nxt = d_r;
      rd_nxt = rd_r;
      case (st_r)
         C_IDLE: if (req_i) begin
            st_nxt = C_POLL;
            cmd_nxt = cmd_i;
            ld_nxt = is_load_i;
            z_nxt = zptr_i;
            d_nxt = data_i;
         end
         C_POLL: if (!bus.ctl_rdata[CTL_ENABLE] && !ee_busy_i) st_nxt = C_WR;
         C_WR: st_nxt = C_ACC;
         C_ACC: st_nxt = ld_r ? C_CAP : C_IDLE;
         C_CAP: begin
            rd_nxt = bus.load_data;
            st_nxt = C_IDLE;
         end
         default: st_nxt = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r <= C_IDLE;
         cmd_r <= '0;
         ld_r <= 1'b0;
         z_r <= '0;
         d_r <= '0;
         rd_r <= '0;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         ld_r <= ld_nxt;
         z_r <= z_nxt;
         d_r <= d_nxt;
         rd_r <= rd_nxt;
      end
   end

   // Access follows the control write in the very next cycle
   assign bus.ctl_wr = (st_r == C_WR);
   assign bus.ctl_wdata = cmd_r;
   assign bus.zptr = z_r;
   assign bus.r1r0 = d_r;
   assign bus.pm_load = (st_r == C_ACC) && ld_r;
   assign bus.spm = (st_r == C_ACC) && !ld_r;
   assign bus.eeprom_write_busy = ee_busy_i;
   assign busy_o = (st_r != C_IDLE);
   assign done_o = (st_r == C_CAP) || (st_r == C_ACC && !ld_r);
   assign rdata_o = rd_r;
   assign status_o = bus.ctl_rdata;
endmodule : fsp_core
`default_nettype wire

/* verification/fsp_link_monitor.sv */
// Checker on the core to controller link: timed windows, programming.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fsp_link_monitor import fsp_pkg::*; #(
   parameter int PROG_CYC = 20 // Programming duration
) (
   input wire logic clk, // CPU clock
   input wire logic rst_n_i, // Reset, active low
   input wire logic ctl_wr, // Control write strobe
   input wire logic [7:0] ctl_wdata, // Control write data
   input wire logic [7:0] ctl_rdata, // Control register value
   input wire logic [15:0] zptr, // Index pointer
   input wire logic pm_load, // Load strobe
   input wire logic spm, // Store strobe
   input wire logic [7:0] load_data, // Load result
   input wire logic eeprom_write_busy // EEPROM busy
);
   localparam int P_LO = PROG_CYC - 1;
   localparam int P_HI = PROG_CYC + 2;
   logic idle;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n_i);
   // A write is only taken with enable clear and EEPROM idle
   assign idle = !ctl_rdata[CTL_ENABLE] && !eeprom_write_busy;
   // Accepted control write of one pattern
   sequence take_s(logic [6:0] p);
      ctl_wr && idle && ctl_wdata[6:0] == p;
   endsequence
   // Erase or legal page write launched by a store
   sequence prog_s;
      spm && ctl_rdata[CTL_ENABLE] && (ctl_rdata[CTL_ERASE]
         || ctl_rdata[CTL_WRITE] && zptr[7:1] == 7'h00);
   endsequence
   a_cmd_latch: assert property (ctl_wr && idle |=> ctl_rdata[5:0] == $past(ctl_wdata[5:0]))
      else $error("control write not taken");
   a_sig_clear: assert property (take_s(CMD_SIG_READ) |-> ##[1:4] !ctl_rdata[CTL_SIG_SEL])
      else $error("signature select stuck");
   a_lock_read_done: assert property (take_s(CMD_LOCK_READ) ##[1:3] pm_load
      |-> ##[1:2] !ctl_rdata[CTL_ENABLE])
      else $error("lock select not cleared");
   a_load_stands: assert property (!$past(pm_load) |-> $stable(load_data))
      else $error("load result moved");
   a_prog_held: assert property (prog_s |=> ctl_rdata[CTL_ENABLE] [*8])
      else $error("enable dropped early");
   a_prog_end: assert property (prog_s |-> ##[P_LO:P_HI] !ctl_rdata[CTL_ENABLE])
      else $error("programming length wrong");
   a_rww_busy: assert property (prog_s |-> ##[1:2] ctl_rdata[CTL_RWW_BUSY])
      else $error("section busy not set");
   a_rww_clear: assert property (spm && ctl_rdata[CTL_REENABLE] && ctl_rdata[CTL_ENABLE]
      |-> ##[1:2] !ctl_rdata[CTL_RWW_BUSY])
      else $error("section busy not cleared");
   a_bad_write: assert property (take_s(CMD_PAGE_WRITE) ##[1:3] (spm && zptr[7:1] != 7'h00)
      |-> ##[1:4] !ctl_rdata[CTL_ENABLE])
      else $error("bad page write kept");
endmodule : fsp_link_monitor
`default_nettype wire

/* verification/flash_selfprog_config_readback_tb_top.sv */
// Bench joining core and controller ends over one link.
// Assumes a short programming count so each write ends quickly.
`timescale 1ns/10ps
`default_nettype none
module flash_selfprog_config_readback_tb_top;
   import fsp_pkg::*;
   localparam int PCYC = 20; // Short programming count
   localparam logic [7:0] SIG1 = 8'ha7; // Arbitrary identity value
   localparam logic [7:0] SIG2 = 8'h4e; // Arbitrary identity value
   localparam logic [7:0] SIG3 = 8'hc2; // Arbitrary identity value
   logic clk_i = 1'b0, rst_n_i = 1'b0, req_i = 1'b0, is_load_i = 1'b0, ee_busy_i = 1'b0;
   logic [7:0] cmd_i = 8'h00, fl_i = 8'hff, fh_i = 8'hff, cal_i = 8'h6b, frd_i = 8'h00;
   logic [15:0] zptr_i = 16'h0000, data_i = 16'h0000;
   logic [5:0] lock_i = 6'h3f;
   logic [2:0] fe_i = 3'h7;
   wire logic busy_o, done_o, erase_o, write_o, lockw_o;
   wire logic [7:0] rdata_o;
   wire logic [7:0] status_o;
   wire logic [5:0] lock_wdata_o;
   wire logic [15:0] boot_start_o;
   wire logic [15:0] page_o;
   wire logic [12:0] boot_words_o;
   logic [31:0] lfsr_r = 32'h4fd2c360;
   int fails = 0, checks = 0, cyc = 0;
   // Clock
   always #50 clk_i = ~clk_i;
   fsp_if fsp_if_inst (.clk(clk_i));
   fsp_ctrl #(.PROG_CYC(PCYC), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .SIG_BYTE3(SIG3))
      fsp_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(fsp_if_inst),
      .lock_bits_i(lock_i), .fuse_low_byte_i(fl_i), .fuse_high_byte_i(fh_i),
      .extended_fuse_byte_i(fe_i), .osc_cal_i(cal_i), .flash_rdata_i(frd_i),
      .flash_erase_o(erase_o), .flash_write_o(write_o), .lock_write_o(lockw_o),
      .lock_wdata_o(lock_wdata_o), .prog_page_o(page_o), .boot_start_o(boot_start_o),
      .boot_words_o(boot_words_o));
   fsp_core fsp_core_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(fsp_if_inst),
      .req_i(req_i), .cmd_i(cmd_i), .is_load_i(is_load_i), .zptr_i(zptr_i),
      .data_i(data_i), .ee_busy_i(ee_busy_i), .busy_o(busy_o), .done_o(done_o),
      .rdata_o(rdata_o), .status_o(status_o));
   fsp_link_monitor #(.PROG_CYC(PCYC)) fsp_link_monitor_inst (.clk(fsp_if_inst.clk),
      .rst_n_i(rst_n_i), .ctl_wr(fsp_if_inst.ctl_wr), .ctl_wdata(fsp_if_inst.ctl_wdata),
      .ctl_rdata(fsp_if_inst.ctl_rdata), .zptr(fsp_if_inst.zptr),
      .pm_load(fsp_if_inst.pm_load),
      .spm(fsp_if_inst.spm), .load_data(fsp_if_inst.load_data),
      .eeprom_write_busy(fsp_if_inst.eeprom_write_busy));
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   // Signature row contents, holes read as reserved
   function automatic logic [7:0] sig_exp(input int z);
      case (z)
         0: return SIG1;
         1: return cal_i;
         2: return SIG2;
         4: return SIG3;
         default: return 8'hff;
      endcase
   endfunction : sig_exp
   // Boot size: words double as the code falls, start sits below 0x8000
   function automatic logic [28:0] boot_exp(input logic [1:0] c);
      logic [12:0] w;
      w = 13'h0200 << (2'd3 - c);
      return {16'h8000 - {3'b000, w}, w};
   endfunction : boot_exp
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   // One command through the core; returns at the negedge after the done cycle
   task automatic run(input logic [7:0] c, input logic ld, input logic [15:0] z,
                      input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      req_i <= 1'b1;
      cmd_i <= c;
      is_load_i <= ld;
      zptr_i <= z;
      data_i <= d;
      @(posedge clk_i);
      req_i <= 1'b0;
      while (done_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      // Load result is captured at the edge that ends the done cycle
      @(negedge clk_i);
      check(n < 200, 1'b1);
   endtask : run
   // Wait out a running flash operation, bounded
   task automatic prog_wait(output int n);
      n = 0;
      while ((erase_o | write_o | lockw_o) === 1'b1 && n < 500) begin
         @(negedge clk_i);
         n++;
      end
   endtask : prog_wait
   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      int i, n;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // Fuse and lock readback with random contents, then a plain load
      for (i = 0; i < 8; i++) begin
         lfsr_r = lfsr_next(lfsr_r);
         @(posedge clk_i);
         {frd_i, fl_i, fh_i, lock_i, fe_i} <= {lfsr_r[0], lfsr_r};
         run(8'h09, 1'b1, 16'(i % 4), 16'h0000);
         case (i % 4)
            0: check(rdata_o, fl_i);
            1: check(rdata_o[5:0], lock_i);
            2: check(rdata_o[2:0], fe_i);
            default: check(rdata_o, fh_i);
         endcase
         run(8'h00, 1'b1, 16'(i % 4), 16'h0000);
         check(rdata_o, frd_i);
      end
      $display("test config readback done");
      // Signature row over addresses 0 to 5, including reserved holes 3 and 5
      for (i = 0; i < 6; i++) begin
         run(8'h21, 1'b1, 16'(i), 16'h0000);
         check(rdata_o, sig_exp(i));
         run(8'h00, 1'b1, 16'(i), 16'h0000);
         check(rdata_o, frd_i);
      end
      $display("test signature done");
      // Boot size decode for all four codes
      for (i = 0; i < 4; i++) begin
         @(posedge clk_i);
         fh_i <= {5'h1f, 2'(i), 1'b1};
         @(negedge clk_i);
         check({boot_start_o, boot_words_o}, boot_exp(2'(i)));
      end
      $display("test boot size done");
      // Page erase: length, enable held, section busy, then re-enable
      run(8'h03, 1'b0, 16'h0100, 16'h0000);
      @(negedge clk_i);
      check({erase_o, status_o[CTL_ENABLE]}, 2'b11);
      check(page_o, 16'h0100);
      prog_wait(n);
      check(n >= PCYC - 3 && n <= PCYC + 1, 1'b1);
      check(status_o[CTL_RWW_BUSY], 1'b1);
      run(8'h11, 1'b0, 16'h0000, 16'h0000);
      repeat (2) @(negedge clk_i);
      check(status_o[CTL_RWW_BUSY], 1'b0);
      // Page write cut by a reset still finishes
      run(8'h05, 1'b0, 16'h0200, 16'h0000);
      repeat (5) @(negedge clk_i);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      check(write_o, 1'b1);
      prog_wait(n);
      check(n > 0 && n < PCYC, 1'b1);
      run(8'h11, 1'b0, 16'h0000, 16'h0000);
      // Page write with word bits set is ignored
      run(8'h05, 1'b0, 16'h0202, 16'h0000);
      @(negedge clk_i);
      check(write_o, 1'b0);
      repeat (6) @(negedge clk_i);
      check(status_o[CTL_ENABLE], 1'b0);
      // Lock write carries the low data bits
      run(8'h09, 1'b0, 16'h0001, 16'h00e5);
      @(negedge clk_i);
      check({lockw_o, lock_wdata_o}, 7'h65);
      prog_wait(n);
      check(n >= PCYC - 3 && n <= PCYC + 1, 1'b1);
      $display("test programming done");
      // EEPROM busy holds the command back
      @(posedge clk_i);
      ee_busy_i <= 1'b1;
      fork
         run(8'h21, 1'b1, 16'h0002, 16'h0000);
         begin
            repeat (10) @(negedge clk_i);
            check(busy_o, 1'b1);
            @(posedge clk_i);
            ee_busy_i <= 1'b0;
         end
      join
      check(rdata_o, SIG2);
      $display("test eeprom hold done");
      conclude();
   end
endmodule : flash_selfprog_config_readback_tb_top
`default_nettype wire
